// [hw/rmd_decode.sv]
// Registered decoder of one remap table entry into delivery attributes.
`timescale 1ns/1ps
module rmd_decode
    import rmd_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Entry words and configuration.
    input wire logic [DATA_W-1:0] entry_lo_i,
    input wire logic [DATA_W-1:0] entry_hi_i,
    input wire logic mode32_i,
    input wire logic nmi_report_i,
    // Decoded result.
    output rmd_dec_t dec_o
);

    // ==================================================================
    // Field extraction
    logic [2:0] kind_w;
    logic present_w;
    logic sense_w;
    logic [7:0] vec_raw_w;
    logic [DATA_W-1:0] tgt_raw_w;
    logic [DATA_W-1:0] tgt_sel_w;

    // The kind, sense and vector fields come from the low word.
    assign kind_w = entry_lo_i[DK_MSB:DK_LSB];
    assign present_w = entry_lo_i[PRESENT_POS];
    assign sense_w = entry_lo_i[SENSE_POS];
    assign vec_raw_w = entry_lo_i[VEC_MSB:VEC_LSB];

    // Narrow mode uses only one byte of the target word.
    assign tgt_raw_w = mode32_i ? entry_hi_i :
        {{(DATA_W-TGT8_W){1'b0}}, entry_hi_i[TGT8_MSB:TGT8_LSB]};

    // ==================================================================
    // Kind classification
    logic is_fixed_w;
    logic is_lowest_w;
    logic is_sme_w;
    logic is_nmi_w;
    logic is_init_w;
    logic supported_w;
    logic edge_only_w;
    logic vec_ignored_w;

    // Codes outside the listed set are refused.
    assign is_fixed_w = (kind_w == KIND_FIXED);
    assign is_lowest_w = (kind_w == KIND_LOWEST);
    assign is_sme_w = (kind_w == KIND_SME);
    assign is_nmi_w = (kind_w == KIND_NMI);
    assign is_init_w = (kind_w == KIND_INIT);
    assign supported_w = is_fixed_w | is_lowest_w | is_sme_w |
        is_nmi_w | is_init_w;
    assign edge_only_w = is_sme_w | is_nmi_w | is_init_w;
    assign vec_ignored_w = is_sme_w | is_init_w |
        (is_nmi_w & ~nmi_report_i);

    // One agent only for the single-target kind: the lowest set bit.
    assign tgt_sel_w = is_lowest_w ? rmd_lowest_bit(tgt_raw_w) :
        tgt_raw_w;

    // ==================================================================
    // Result assembly; fields of an absent entry other than its kind are not evaluated
    rmd_dec_t dec_nxt;

    always_comb begin
        dec_nxt = '0;
        dec_nxt.kind = kind_w;
        dec_nxt.absent = ~present_w;
        if (present_w) begin
            dec_nxt.target = tgt_sel_w;
            dec_nxt.vector = vec_ignored_w ? 8'h00 : vec_raw_w;
            dec_nxt.level = ~edge_only_w &
                (sense_w == SENSE_LEVEL);
            dec_nxt.single = is_lowest_w;
            dec_nxt.to_pin = is_nmi_w;
            dec_nxt.unsup = ~supported_w;
            dec_nxt.deliver = supported_w & (tgt_sel_w != '0);
        end
    end

    // Result register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_o <= '0;
        end else begin
            dec_o <= dec_nxt;
        end
    end

endmodule

// [hw/rmd_top.sv]
// APB-controlled sequencer that delivers interrupts from a decoded entry.
`timescale 1ns/1ps
module rmd_top
    import rmd_pkg::*;
#(
    parameter int CW = CNT_W
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    output logic [DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Delivery message to the processor receivers.
    output logic dlv_valid_o,
    output logic [2:0] dlv_kind_o,
    output logic dlv_level_o,
    output logic dlv_single_o,
    output logic [7:0] dlv_vector_o,
    output logic [DATA_W-1:0] dlv_target_o,
    // Dedicated non-maskable pin.
    output logic nmi_pin_o
);

    // ==================================================================
    // APB decode
    logic access_w;
    logic ack_w;
    logic wr_w;
    logic rd_phase_w;
    logic hit_lo_w;
    logic hit_hi_w;
    logic hit_cfg_w;
    logic hit_cmd_w;
    logic hit_sts_w;
    logic mapped_w;

    // Writes act at the edge where the master sees pready high.
    assign access_w = psel_i & penable_i;
    assign ack_w = access_w & pready_o;
    assign wr_w = ack_w & pwrite_i;
    assign rd_phase_w = access_w & ~pready_o;
    assign hit_lo_w = (paddr_i == OFF_ENTRY_LO);
    assign hit_hi_w = (paddr_i == OFF_ENTRY_HI);
    assign hit_cfg_w = (paddr_i == OFF_CFG);
    assign hit_cmd_w = (paddr_i == OFF_CMD);
    assign hit_sts_w = (paddr_i == OFF_STATUS);
    assign mapped_w = hit_lo_w | hit_hi_w | hit_cfg_w | hit_cmd_w |
        hit_sts_w;

    // ==================================================================
    // Registers and state
    logic [DATA_W-1:0] entry_lo_r;
    logic [DATA_W-1:0] entry_hi_r;
    logic [1:0] cfg_r;
    logic unsup_r;
    logic absent_r;
    logic [CW-1:0] cnt_r;
    rmd_state_t state_r;
    rmd_state_t state_nxt;
    rmd_dec_t dec_w;

    // Command and status-clear strobes.
    logic fire_w;
    logic release_w;
    logic clr_unsup_w;
    logic clr_absent_w;

    assign fire_w = wr_w & hit_cmd_w & pwdata_i[CMD_FIRE_POS];
    assign release_w = wr_w & hit_cmd_w & pwdata_i[CMD_RELEASE_POS];
    assign clr_unsup_w = wr_w & hit_sts_w & pwdata_i[STS_UNSUP_POS];
    assign clr_absent_w = wr_w & hit_sts_w & pwdata_i[STS_ABSENT_POS];

    // Status word: busy, level held, sticky refusals, delivery count.
    logic [DATA_W-1:0] status_w;
    logic [DATA_W-1:0] rdata_w;

    always_comb begin
        status_w = '0;
        status_w[STS_BUSY_POS] = (state_r != ST_IDLE);
        status_w[STS_LEVEL_POS] = dlv_level_o;
        status_w[STS_UNSUP_POS] = unsup_r;
        status_w[STS_ABSENT_POS] = absent_r;
        status_w[STS_CNT_LSB +: CW] = cnt_r;
    end

    // Read selection; the command register and holes read as zero.
    assign rdata_w = hit_lo_w ? entry_lo_r :
        hit_hi_w ? entry_hi_r :
        hit_cfg_w ? {{(DATA_W-2){1'b0}}, cfg_r} :
        hit_sts_w ? status_w : '0;

    // ==================================================================
    // APB response: one wait state, error on an unmapped address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end else begin
            pready_o <= rd_phase_w;
            pslverr_o <= rd_phase_w & ~mapped_w;
            prdata_o <= (rd_phase_w & ~pwrite_i) ? rdata_w : '0;
        end
    end

    // Entry and configuration registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            entry_lo_r <= ENTRY_RST;
            entry_hi_r <= ENTRY_RST;
            cfg_r <= CFG_RST;
        end else begin
            if (wr_w & hit_lo_w) begin
                entry_lo_r <= pwdata_i;
            end
            if (wr_w & hit_hi_w) begin
                entry_hi_r <= pwdata_i;
            end
            if (wr_w & hit_cfg_w) begin
                cfg_r <= pwdata_i[1:0];
            end
        end
    end

    // ==================================================================
    // Entry decoder, registered one cycle behind the entry words
    rmd_decode u_decode (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .entry_lo_i(entry_lo_r),
        .entry_hi_i(entry_hi_r),
        .mode32_i(cfg_r[CFG_MODE32_POS]),
        .nmi_report_i(cfg_r[CFG_NMIREP_POS]),
        .dec_o(dec_w)
    );

    // ==================================================================
    // Sequencer
    logic go_msg_w;
    logic go_pin_w;
    logic in_decode_w;

    assign in_decode_w = (state_r == ST_DECODE);
    assign go_msg_w = in_decode_w & dec_w.deliver & ~dec_w.to_pin;
    assign go_pin_w = in_decode_w & dec_w.deliver & dec_w.to_pin;

    // Next state; a fire while busy is ignored.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (fire_w) begin
                    state_nxt = ST_DECODE;
                end
            end
            ST_DECODE: begin
                if (dec_w.deliver) begin
                    state_nxt = ST_SEND;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_SEND: begin
                if (dlv_level_o & ~release_w) begin
                    state_nxt = ST_HOLD;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (release_w) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Message strobe and dedicated pin are one-cycle pulses.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dlv_valid_o <= 1'b0;
            nmi_pin_o <= 1'b0;
        end else begin
            dlv_valid_o <= go_msg_w;
            nmi_pin_o <= go_pin_w;
        end
    end

    // Message fields stay stable until the next delivery.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dlv_kind_o <= KIND_FIXED;
            dlv_single_o <= 1'b0;
            dlv_vector_o <= 8'h00;
            dlv_target_o <= '0;
        end else if (go_msg_w | go_pin_w) begin
            dlv_kind_o <= dec_w.kind;
            dlv_single_o <= dec_w.single;
            dlv_vector_o <= dec_w.vector;
            dlv_target_o <= dec_w.target;
        end
    end

    // A level delivery stays asserted until software releases it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dlv_level_o <= 1'b0;
        end else if (go_msg_w) begin
            dlv_level_o <= dec_w.level;
        end else if (release_w | (state_r == ST_IDLE)) begin
            dlv_level_o <= 1'b0;
        end
    end

    // Sticky refusal flags; a new refusal wins over a clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unsup_r <= 1'b0;
            absent_r <= 1'b0;
        end else begin
            unsup_r <= (in_decode_w & dec_w.unsup) |
                (unsup_r & ~clr_unsup_w);
            absent_r <= (in_decode_w & dec_w.absent) |
                (absent_r & ~clr_absent_w);
        end
    end

    // Count of deliveries made, wrapping.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= CNT_RST;
        end else if (go_msg_w | go_pin_w) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // ==================================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_fire;
        fire_w && (state_r == ST_IDLE);
    endsequence

    sequence s_refused;
        in_decode_w && !dec_w.deliver;
    endsequence

    AST_FIRE_TO_DECODE: assert property (
        s_fire |=> (state_r == ST_DECODE) ##1 (state_r != ST_DECODE))
        else $error("Fire did not pass through one decode cycle.");

    AST_REFUSED_SILENT: assert property (
        s_refused |=> !dlv_valid_o && !nmi_pin_o [*2])
        else $error("Refused entry produced a delivery.");

    AST_SME_EDGE: assert property (
        dlv_valid_o && dlv_kind_o == KIND_SME
        |-> !dlv_level_o && dlv_vector_o == 8'h00)
        else $error("Management event not edge or vector not ignored.");

    AST_INIT_EDGE: assert property (
        dlv_valid_o && dlv_kind_o == KIND_INIT
        |-> !dlv_level_o && dlv_vector_o == 8'h00)
        else $error("Initialization not edge or vector not ignored.");

    AST_NMI_PIN: assert property (
        nmi_pin_o |-> !dlv_valid_o && !dlv_level_o ##1 !nmi_pin_o)
        else $error("Non-maskable pin not a lone one-cycle pulse.");

    AST_NMI_VEC: assert property (
        nmi_pin_o && !cfg_r[CFG_NMIREP_POS] && !$past(wr_w)
        |-> dlv_vector_o == 8'h00)
        else $error("Non-maskable vector kept without source reporting.");

    AST_LEVEL_HOLD: assert property (
        dlv_level_o && !release_w |=> dlv_level_o)
        else $error("Level delivery dropped before release.");

    AST_LEVEL_END: assert property (
        dlv_level_o && release_w |=> !dlv_level_o && state_r == ST_IDLE)
        else $error("Level delivery not ended by release.");

    AST_SINGLE: assert property (
        dlv_valid_o && dlv_kind_o == KIND_LOWEST
        |-> $onehot(dlv_target_o) && dlv_single_o)
        else $error("Single-target delivery names more than one agent.");

    AST_ABSENT: assert property (
        in_decode_w && dec_w.absent |=> absent_r && !dlv_valid_o)
        else $error("Absent entry not flagged or was delivered.");

    AST_NARROW: assert property (
        dlv_valid_o && !cfg_r[CFG_MODE32_POS] && !$past(wr_w)
        |-> dlv_target_o[DATA_W-1:TGT8_W] == '0)
        else $error("Narrow mode target uses upper bits.");

    AST_READY_PULSE: assert property (
        pready_o |=> !pready_o)
        else $error("Ready held for more than one cycle.");

endmodule

// [inc/rmd_pkg.sv]
// Shared constants, types and helpers of the remap entry delivery decoder.
package rmd_pkg;

    // ==================================================================
    // Bus geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 8;

    // ==================================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_ENTRY_LO = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_ENTRY_HI = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CFG = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;

    // ==================================================================
    // Reset values
    localparam logic [DATA_W-1:0] ENTRY_RST = 32'h0000_0000;
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

    // ==================================================================
    // Field positions inside the low and high words of the entry
    localparam int PRESENT_POS = 0;
    localparam int SENSE_POS = 4;
    localparam int DK_LSB = 5;
    localparam int DK_MSB = 7;
    localparam int VEC_LSB = 16;
    localparam int VEC_MSB = 23;
    localparam int TGT8_LSB = 8;
    localparam int TGT8_MSB = 15;
    localparam int TGT8_W = 8;

    // ==================================================================
    // Control and status bit positions
    localparam int CFG_MODE32_POS = 0;
    localparam int CFG_NMIREP_POS = 1;
    localparam int CMD_FIRE_POS = 0;
    localparam int CMD_RELEASE_POS = 1;
    localparam int STS_BUSY_POS = 0;
    localparam int STS_LEVEL_POS = 1;
    localparam int STS_UNSUP_POS = 2;
    localparam int STS_ABSENT_POS = 3;
    localparam int STS_CNT_LSB = 8;

    // ==================================================================
    // Delivery kind codes and the signal sense value for level
    localparam logic [2:0] KIND_FIXED = 3'h0;
    localparam logic [2:0] KIND_LOWEST = 3'h1;
    localparam logic [2:0] KIND_SME = 3'h2;
    localparam logic [2:0] KIND_NMI = 3'h4;
    localparam logic [2:0] KIND_INIT = 3'h5;
    localparam logic SENSE_LEVEL = 1'b1;

    // ==================================================================
    // Decoded entry as it travels from the decoder to the sequencer
    typedef struct packed {
        logic [DATA_W-1:0] target;
        logic [7:0] vector;
        logic [2:0] kind;
        logic level;
        logic single;
        logic to_pin;
        logic deliver;
        logic unsup;
        logic absent;
    } rmd_dec_t;

    // Sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_DECODE = 4'h2,
        ST_SEND = 4'h4,
        ST_HOLD = 4'h8
    } rmd_state_t;

    // Keeps only the lowest set bit of an agent mask.
    function automatic logic [DATA_W-1:0] rmd_lowest_bit(
        input logic [DATA_W-1:0] m);
        return m & (~m + 32'h0000_0001);
    endfunction

endpackage

// [tb/rmd_rx_model.sv]
// Behavioural model of the processor interrupt receivers.
`timescale 1ns/1ps
module rmd_rx_model
    import rmd_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Delivery message and pin from the block.
    input wire logic dlv_valid_i,
    input wire logic [2:0] dlv_kind_i,
    input wire logic dlv_single_i,
    input wire logic [7:0] dlv_vector_i,
    input wire logic [DATA_W-1:0] dlv_target_i,
    input wire logic nmi_pin_i,
    // What the receivers have seen.
    output logic [7:0] msg_cnt_o,
    output logic [7:0] nmi_cnt_o,
    output logic [2:0] last_kind_o,
    output logic last_single_o,
    output logic [7:0] last_vector_o,
    output logic [DATA_W-1:0] last_target_o
);
    // ==================================================================
    // Receivers
    // Each message pulse is latched once; the pin is counted apart.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msg_cnt_o <= 8'h00;
            nmi_cnt_o <= 8'h00;
            last_kind_o <= 3'h0;
            last_single_o <= 1'b0;
            last_vector_o <= 8'h00;
            last_target_o <= 32'h0000_0000;
        end else begin
            if (dlv_valid_i) begin
                msg_cnt_o <= msg_cnt_o + 8'h01;
                last_kind_o <= dlv_kind_i;
                last_single_o <= dlv_single_i;
                last_vector_o <= dlv_vector_i;
                last_target_o <= dlv_target_i;
            end
            if (nmi_pin_i) begin
                nmi_cnt_o <= nmi_cnt_o + 8'h01;
            end
        end
    end
endmodule

// [tb/testbench.sv]
// Self-checking testbench of the remap entry delivery sequencer.
`timescale 1ns/1ps
module testbench;
    import rmd_pkg::*;
    // ==================================================================
    // Signals
    logic clk_i = 1'b0;
    logic rst_i, psel_i, penable_i, pwrite_i;
    logic [ADDR_W-1:0] paddr_i;
    logic [DATA_W-1:0] pwdata_i, prdata_o, dlv_target_o, rd, l_tgt;
    logic pready_o, pslverr_o, dlv_valid_o, dlv_level_o, dlv_single_o;
    logic nmi_pin_o, err, l_single;
    logic [2:0] dlv_kind_o, l_kind;
    logic [7:0] dlv_vector_o, msg_cnt, nmi_cnt, m0, n0, l_vec;
    int fails, total_checks;

    rmd_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .dlv_valid_o(dlv_valid_o),
        .dlv_kind_o(dlv_kind_o), .dlv_level_o(dlv_level_o),
        .dlv_single_o(dlv_single_o), .dlv_vector_o(dlv_vector_o),
        .dlv_target_o(dlv_target_o), .nmi_pin_o(nmi_pin_o));

    rmd_rx_model rx_u (.clk_i(clk_i), .rst_i(rst_i),
        .dlv_valid_i(dlv_valid_o), .dlv_kind_i(dlv_kind_o),
        .dlv_single_i(dlv_single_o), .dlv_vector_i(dlv_vector_o),
        .dlv_target_i(dlv_target_o), .nmi_pin_i(nmi_pin_o),
        .msg_cnt_o(msg_cnt), .nmi_cnt_o(nmi_cnt), .last_kind_o(l_kind),
        .last_single_o(l_single), .last_vector_o(l_vec),
        .last_target_o(l_tgt));

    // The clock toggles every 4 ns, a period of 8 ns.
    always #4 clk_i = ~clk_i;

    // ==================================================================
    // Tasks
    // Compares a value seen with the value expected.
    task automatic chk(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; pready and the answer are watched where settled,
    // and the request is released only after the edge that takes it.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(negedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        @(posedge clk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Loads the low entry word, fires and waits past the fixed answer.
    task automatic fire(input logic [DATA_W-1:0] lo);
        apb(1'b1, OFF_ENTRY_LO, lo);
        m0 = msg_cnt;
        n0 = nmi_cnt;
        apb(1'b1, OFF_CMD, 32'h0000_0001);
        repeat (4) @(posedge clk_i);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==================================================================
    // Watchdog
    // Cuts a hang short well beyond the expected run length.
    initial begin
        #200000;
        fails++;
        end_of_test();
    end

    // ==================================================================
    // Tests
    // Resets the block, then works through the kind table and cases.
    initial begin
        logic [2:0] kb;
        logic lv;
        logic [DATA_W-1:0] ent;
        rst_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0000_0000;
        fails = 0;
        total_checks = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk("status_reset", rd, 32'h0000_0000);
        apb(1'b0, OFF_CFG, 32'h0000_0000);
        chk("cfg_reset", rd, 32'h0000_0000);
        chk("kind_reset", {29'h0, dlv_kind_o}, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped_err", {31'h0, err}, 32'h0000_0001);
        chk("unmapped_data", rd, 32'h0000_0000);
        $display("test reset done");
        // Wide targets, agents 10 and 11 named, sense level, vector A5.
        apb(1'b1, OFF_CFG, 32'h0000_0001);
        apb(1'b1, OFF_ENTRY_HI, 32'h0000_0C00);
        for (int k = 0; k < 8; k++) begin
            kb = k[2:0];
            lv = (k < 2);
            // Management event entries keep their vector at zero.
            ent = (k == 2) ? 32'h0000_0011 : 32'h00A5_0011;
            fire(ent | ({29'h0, kb} << 5));
            chk("msg_seen", {24'h0, msg_cnt - m0},
                (k < 3 || k == 5) ? 32'h1 : 32'h0);
            chk("nmi_seen", {24'h0, nmi_cnt - n0},
                (k == 4) ? 32'h1 : 32'h0);
            chk("level_out", {31'h0, dlv_level_o}, {31'h0, lv});
            if (k < 3 || k == 5) begin
                chk("kind", {29'h0, l_kind}, {29'h0, kb});
                chk("vector", {24'h0, l_vec},
                    lv ? 32'hA5 : 32'h0);
                chk("target", l_tgt,
                    (k == 1) ? 32'h0400 : 32'h0C00);
                chk("single", {31'h0, l_single},
                    (k == 1) ? 32'h1 : 32'h0);
            end
            if (k == 4) begin
                chk("nmi_vector", {24'h0, dlv_vector_o}, 32'h0);
                chk("nmi_target", dlv_target_o, 32'h0000_0C00);
            end
            apb(1'b0, OFF_STATUS, 32'h0000_0000);
            chk("status_flags", {28'h0, rd[3:0]},
                {29'h0, (k == 3 || k > 5), lv, lv});
            if (k == 0) begin
                chk("count", {24'h0, rd[15:8]}, 32'h1);
            end
            apb(1'b1, OFF_CMD, 32'h0000_0002);
            apb(1'b1, OFF_STATUS, 32'h0000_000C);
            chk("released", {31'h0, dlv_level_o}, 32'h0);
        end
        $display("test kinds done");
        // Source reporting on: a non-maskable entry keeps its vector.
        apb(1'b1, OFF_CFG, 32'h0000_0003);
        fire(32'h00A5_0081);
        chk("report_pin", {24'h0, nmi_cnt - n0}, 32'h1);
        chk("report_vec", {24'h0, dlv_vector_o}, 32'hA5);
        $display("test report done");
        // Narrow target mode, fixed kind with edge sense.
        apb(1'b1, OFF_CFG, 32'h0000_0000);
        apb(1'b1, OFF_ENTRY_HI, 32'h0000_AB00);
        fire(32'h0033_0001);
        chk("narrow_msg", {24'h0, msg_cnt - m0}, 32'h1);
        chk("narrow_target", l_tgt, 32'h0000_00AB);
        chk("edge_sense", {31'h0, dlv_level_o}, 32'h0);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk("edge_idle", {31'h0, rd[0]}, 32'h0);
        $display("test narrow done");
        // Entry not present: nothing delivered, absent flag raised.
        fire(32'h0055_0010);
        chk("absent_msg", {24'h0, msg_cnt - m0}, 32'h0);
        chk("absent_level", {31'h0, dlv_level_o}, 32'h0);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk("absent_flag", {28'h0, rd[3:0]}, 32'h8);
        apb(1'b1, OFF_STATUS, 32'h0000_0008);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk("absent_clear", {28'h0, rd[3:0]}, 32'h0);
        $display("test absent done");
        end_of_test();
    end
endmodule
